// *** rtl/eic_top.sv ***
/*
 * External interrupt input conditioner: five filtered pins, edge detection,
 * sticky interrupt latches with enables, and an AXI4-Lite register slave.
 * Assumes pins synchronous to clock_i and one AXI master.
 */

`timescale 1ns/1ps
`default_nettype none

module eic_top #(
    parameter int AW = 12,
    parameter int LOW_DIV = eic_pkg::FS_DIV
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Pins and system mode
    input wire logic [eic_pkg::NUM_IRQ-1:0] irq_pin_i,
    input wire logic slow_mode_i,
    // Port side of the shared pin and interrupt
    output logic shared_port_pin_o,
    output logic irq_o,
    // AXI4-Lite write
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int N = eic_pkg::NUM_IRQ;
    localparam int CW = eic_pkg::FILT_CW;

    if (AW < 10)
    begin : g_bad_aw
        $error("eic_top: AW must cover the register indices");
    end
    if (eic_pkg::B_LONG_THRESH >= (1 << CW))
    begin : g_bad_cw
        $error("eic_top: filter counter too narrow");
    end

    // Low-clock enable and filters
    logic fs_tick;
    logic [N-1:0] lvl;
    logic [CW-1:0] thr [N];
    eic_pkg::eic_ctrl_s ctrl_r;
    eic_pkg::eic_ctrl_s ctrl_nxt;

    eic_lowdiv #(
        .DIV(LOW_DIV)
    ) u_lowdiv (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(fs_tick)
    );

    always_comb
    begin
        if (slow_mode_i)
        begin
            for (int i = 0; i < N; i++)
            begin
                thr[i] = CW'(eic_pkg::SLOW_THRESH);
            end
        end
        else
        begin
            thr[0] = CW'(eic_pkg::AE_THRESH);
            thr[4] = CW'(eic_pkg::AE_THRESH);
            thr[1] = ctrl_r.noise_time_select ? CW'(eic_pkg::B_SHORT_THRESH)
                                              : CW'(eic_pkg::B_LONG_THRESH);
            thr[2] = CW'(eic_pkg::CD_THRESH);
            thr[3] = CW'(eic_pkg::CD_THRESH);
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_filt
            eic_filter #(
                .CW(CW)
            ) u_filt (
                .clock_i(clock_i),
                .sys_rst_i(sys_rst_i),
                .pin_i(irq_pin_i[g]),
                .tick_i(slow_mode_i ? fs_tick : 1'b1),
                .thresh_i(thr[g]),
                .level_o(lvl[g])
            );
        end
    endgenerate

    // Edge detection on filtered levels
    logic [N-1:0] lvl_d_r;
    logic [N-1:0] fall;
    logic [N-1:0] rise;
    logic [N-1:0] evt;

    always_comb
    begin
        fall = lvl_d_r & ~lvl;
        rise = ~lvl_d_r & lvl;
        evt[0] = fall[0] & ctrl_r.pin_func_select;
        evt[1] = ctrl_r.edge_sel_b ? fall[1] : rise[1];
        evt[2] = ctrl_r.edge_sel_c ? fall[2] : rise[2];
        evt[3] = ctrl_r.edge_sel_d ? fall[3] : rise[3];
        evt[4] = fall[4];
    end

    // Register state
    logic [N-1:0] stat_r;
    logic [N-1:0] stat_nxt;
    logic [N-1:0] mask_r;
    logic [N-1:0] mask_nxt;
    logic master_r;
    logic master_nxt;
    logic alt_d_r;
    logic alt_d_nxt;
    logic alt_e_r;
    logic alt_e_nxt;
    logic irq_r;
    logic irq_nxt;
    logic port_r;
    logic port_nxt;
    logic [N-1:0] w1c;
    logic [N-1:0] en_eff;

    // Bus state
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wr_go;
    logic lane0;

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
        hit = (a == AW'({idx, 2'b00}));
    endfunction

    // Write channel: both address and data must be present, then one response
    always_comb
    begin
        wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
        awready_nxt = wr_go;
        wready_nxt = wr_go;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (awready_r)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = (hit(s_axi_awaddr, eic_pkg::CTRL_IDX) | hit(s_axi_awaddr, eic_pkg::STAT_IDX) |
                         hit(s_axi_awaddr, eic_pkg::MASK_IDX) | hit(s_axi_awaddr, eic_pkg::MSTR_IDX))
                        ? eic_pkg::RESP_OKAY : eic_pkg::RESP_SLVERR;
        end
        else if (bvalid_r & s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
    end

    // Register writes happen in the cycle the address and data are taken
    always_comb
    begin
        lane0 = awready_r & s_axi_wstrb[0];
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        master_nxt = master_r;
        alt_d_nxt = alt_d_r;
        alt_e_nxt = alt_e_r;
        w1c = '0;
        if (lane0 & hit(s_axi_awaddr, eic_pkg::CTRL_IDX))
        begin
            ctrl_nxt.noise_time_select = s_axi_wdata[eic_pkg::NOISE_SEL_BIT];
            ctrl_nxt.pin_func_select = s_axi_wdata[eic_pkg::FUNC_SEL_BIT];
            ctrl_nxt.edge_sel_d = s_axi_wdata[eic_pkg::EDGE_D_BIT];
            ctrl_nxt.edge_sel_c = s_axi_wdata[eic_pkg::EDGE_C_BIT];
            ctrl_nxt.edge_sel_b = s_axi_wdata[eic_pkg::EDGE_B_BIT];
        end
        if (lane0 & hit(s_axi_awaddr, eic_pkg::STAT_IDX))
        begin
            w1c = s_axi_wdata[N-1:0];
        end
        if (lane0 & hit(s_axi_awaddr, eic_pkg::MASK_IDX))
        begin
            mask_nxt = s_axi_wdata[N-1:0];
        end
        if (lane0 & hit(s_axi_awaddr, eic_pkg::MSTR_IDX))
        begin
            master_nxt = s_axi_wdata[eic_pkg::MSTR_EN_BIT];
            alt_d_nxt = s_axi_wdata[eic_pkg::ALT_D_BIT];
            alt_e_nxt = s_axi_wdata[eic_pkg::ALT_E_BIT];
        end
    end

    // Latches, request and shared port
    always_comb
    begin
        stat_nxt = (stat_r & ~w1c) | evt;
        en_eff = mask_r & {~alt_e_r, ~alt_d_r, 3'b111};
        irq_nxt = master_r & |(stat_nxt & en_eff);
        port_nxt = ctrl_r.pin_func_select ? port_r : irq_pin_i[0];
    end

    // Read channel
    always_comb
    begin
        arready_nxt = s_axi_arvalid & ~arready_r & ~rvalid_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = eic_pkg::RESP_OKAY;
            rdata_nxt = 32'h0;
            if (hit(s_axi_araddr, eic_pkg::CTRL_IDX))
            begin
                rdata_nxt[eic_pkg::NOISE_SEL_BIT] = ctrl_r.noise_time_select;
                rdata_nxt[eic_pkg::FUNC_SEL_BIT] = ctrl_r.pin_func_select;
                rdata_nxt[eic_pkg::EDGE_D_BIT] = ctrl_r.edge_sel_d;
                rdata_nxt[eic_pkg::EDGE_C_BIT] = ctrl_r.edge_sel_c;
                rdata_nxt[eic_pkg::EDGE_B_BIT] = ctrl_r.edge_sel_b;
            end
            else if (hit(s_axi_araddr, eic_pkg::STAT_IDX))
            begin
                rdata_nxt[N-1:0] = stat_r;
                rdata_nxt[eic_pkg::STAT_LVL_LSB +: N] = lvl;
            end
            else if (hit(s_axi_araddr, eic_pkg::MASK_IDX))
            begin
                rdata_nxt[N-1:0] = mask_r;
            end
            else if (hit(s_axi_araddr, eic_pkg::MSTR_IDX))
            begin
                rdata_nxt[eic_pkg::MSTR_EN_BIT] = master_r;
                rdata_nxt[eic_pkg::ALT_D_BIT] = alt_d_r;
                rdata_nxt[eic_pkg::ALT_E_BIT] = alt_e_r;
            end
            else
            begin
                rresp_nxt = eic_pkg::RESP_SLVERR;
            end
        end
        else if (rvalid_r & s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_r <= eic_pkg::CTRL_RESET;
            stat_r <= '0;
            mask_r <= '0;
            master_r <= 1'b0;
            alt_d_r <= 1'b0;
            alt_e_r <= 1'b0;
            irq_r <= 1'b0;
            port_r <= eic_pkg::LVL_RESET;
            lvl_d_r <= {N{eic_pkg::LVL_RESET}};
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= eic_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= eic_pkg::RESP_OKAY;
            rdata_r <= 32'h0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            master_r <= master_nxt;
            alt_d_r <= alt_d_nxt;
            alt_e_r <= alt_e_nxt;
            irq_r <= irq_nxt;
            port_r <= port_nxt;
            lvl_d_r <= lvl;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign irq_o = irq_r;
    assign shared_port_pin_o = port_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

endmodule

`default_nettype wire

// *** rtl/eic_pkg.sv ***
/*
 * Constants and types of the external interrupt input conditioner.
 * Assumes a single 100 MHz high-frequency clock; the low-frequency clock is an enable pulse.
 */
package eic_pkg;

    // Clock rates
    localparam int FC_HZ = 100_000_000;
    localparam int FS_HZ = 32_768;
    localparam int FS_DIV = FC_HZ / FS_HZ;

    // Number of external interrupt inputs
    localparam int NUM_IRQ = 5;

    // Noise rejection bounds in high-clock periods, and the chosen stable counts
    localparam int AE_REJECT_FC = 2;
    localparam int AE_ACCEPT_FC = 7;
    localparam int AE_THRESH = (AE_REJECT_FC + AE_ACCEPT_FC + 1) / 2;
    localparam int B_SHORT_REJECT_FC = 15;
    localparam int B_SHORT_ACCEPT_FC = 49;
    localparam int B_SHORT_THRESH = (B_SHORT_REJECT_FC + B_SHORT_ACCEPT_FC) / 2;
    localparam int B_LONG_REJECT_FC = 63;
    localparam int B_LONG_ACCEPT_FC = 193;
    localparam int B_LONG_THRESH = (B_LONG_REJECT_FC + B_LONG_ACCEPT_FC) / 2;
    localparam int CD_REJECT_FC = 7;
    localparam int CD_ACCEPT_FC = 25;
    localparam int CD_THRESH = (CD_REJECT_FC + CD_ACCEPT_FC) / 2;
    // In slow or sleep mode: reject under 1 fs, accept from 3.5 fs; count stable fs samples
    localparam int SLOW_THRESH = 2;
    localparam int FILT_CW = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h37;
    localparam logic [7:0] STAT_IDX = 8'h38;
    localparam logic [7:0] MASK_IDX = 8'h39;
    localparam logic [7:0] MSTR_IDX = 8'h3a;

    // Field positions of ext_irq_control
    localparam int NOISE_SEL_BIT = 7;
    localparam int FUNC_SEL_BIT = 6;
    localparam int EDGE_D_BIT = 3;
    localparam int EDGE_C_BIT = 2;
    localparam int EDGE_B_BIT = 1;
    // Field positions of the own registers
    localparam int STAT_LVL_LSB = 8;
    localparam int MSTR_EN_BIT = 0;
    localparam int ALT_D_BIT = 1;
    localparam int ALT_E_BIT = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Filtered level after reset: pins idle high
    localparam logic LVL_RESET = 1'h1;

    typedef struct packed {
        logic noise_time_select;
        logic pin_func_select;
        logic edge_sel_d;
        logic edge_sel_c;
        logic edge_sel_b;
    } eic_ctrl_s;

    localparam eic_ctrl_s CTRL_RESET = '0;

endpackage

// *** rtl/eic_lowdiv.sv ***
/*
 * Divider that makes the low-frequency clock as a one-cycle enable pulse.
 * Assumes the high-frequency clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module eic_lowdiv #(
    parameter int DIV = eic_pkg::FS_DIV
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Low-clock enable
    output logic tick_o
);

    // Refuse divisors that the 16-bit counter cannot serve
    if (DIV < 2 || DIV > 65536)
    begin : g_bad_div
        $error("eic_lowdiv: DIV must be 2 to 65536");
    end

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 16'h1;
        if (cnt_r == 16'(DIV - 1))
        begin
            cnt_nxt = 16'h0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r <= 16'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

endmodule

`default_nettype wire

// *** rtl/eic_filter.sv ***
/*
 * Digital noise filter for one interrupt pin: the output follows the input only
 * after the input has differed from it for thresh_i consecutive counted cycles.
 * Assumes the pin is synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module eic_filter #(
    parameter int CW = eic_pkg::FILT_CW
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Pin and setting
    input wire logic pin_i,
    input wire logic tick_i,
    input wire logic [CW-1:0] thresh_i,
    // Filtered level
    output logic level_o
);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic level_r;
    logic level_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        level_nxt = level_r;
        if (pin_i == level_r)
        begin
            cnt_nxt = '0;
        end
        else if (tick_i)
        begin
            // A changed threshold acts on the very next counted cycle
            if (cnt_r + 1'b1 >= thresh_i)
            begin
                level_nxt = pin_i;
                cnt_nxt = '0;
            end
            else
            begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r <= '0;
            level_r <= eic_pkg::LVL_RESET;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

endmodule

`default_nettype wire

// *** tb/eic_pin_src.sv ***
/*
 * Pin source model: five idle-high interrupt pins; one pin at a time is pulled low
 * for a commanded number of clock cycles.
 * Assumes commands from the bench, one pulse at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module eic_pin_src (
    // Clock
    input wire logic clock_i,
    // Pulse command
    input wire logic go_i,
    input wire logic [2:0] idx_i,
    input wire logic [7:0] len_i,
    // Pins
    output logic [4:0] pin_o
);
    int cnt = 0;

    initial pin_o = 5'h1f; // Shared pin only ever driven into the block as an input

    always @(posedge clock_i)
    begin
        if (go_i)
        begin
            pin_o[idx_i] <= 1'h0;
            cnt <= int'(len_i);
        end
        else if (cnt == 1)
        begin
            pin_o <= 5'h1f;
            cnt <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule

`default_nettype wire

// *** tb/eic_monitor.sv ***
/*
 * Checker of the conditioner's register bus, port copy and interrupt output.
 * Assumes it is bound to eic_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module eic_monitor #(
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Pins and outputs
    input wire logic [eic_pkg::NUM_IRQ-1:0] irq_pin_i,
    input wire logic shared_port_pin_o,
    input wire logic irq_o,
    // Bus
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [AW-1:0] A_CTRL = AW'({eic_pkg::CTRL_IDX, 2'h0});
    localparam logic [AW-1:0] A_STAT = AW'({eic_pkg::STAT_IDX, 2'h0});
    localparam logic [AW-1:0] A_MASK = AW'({eic_pkg::MASK_IDX, 2'h0});
    localparam logic [AW-1:0] A_MSTR = AW'({eic_pkg::MSTR_IDX, 2'h0});

    logic func_r, func_nxt, mstr_r, mstr_nxt, rdc_r, rdc_nxt;

    function automatic logic mapped(input logic [AW-1:0] a);
        return a == A_CTRL || a == A_STAT || a == A_MASK || a == A_MSTR;
    endfunction

    // Shadow of the function bit and master enable, and whether the last read hit ctrl
    always_comb
    begin
        func_nxt = func_r;
        mstr_nxt = mstr_r;
        rdc_nxt = rdc_r;
        if (s_axi_awready && s_axi_wstrb[0] && s_axi_awaddr == A_CTRL)
            func_nxt = s_axi_wdata[eic_pkg::FUNC_SEL_BIT];
        if (s_axi_awready && s_axi_wstrb[0] && s_axi_awaddr == A_MSTR)
            mstr_nxt = s_axi_wdata[eic_pkg::MSTR_EN_BIT];
        if (s_axi_arready)
            rdc_nxt = s_axi_araddr == A_CTRL;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            func_r <= 1'h0;
            mstr_r <= 1'h0;
            rdc_r <= 1'h0;
        end
        else
        begin
            func_r <= func_nxt;
            mstr_r <= mstr_nxt;
            rdc_r <= rdc_nxt;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_wr_taken;
        s_axi_awready && s_axi_wready;
    endsequence

    sequence s_rd_bad;
        s_axi_arready && !mapped(s_axi_araddr);
    endsequence

    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write address taken without write data");
    a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_wr_unmapped: assert property (s_wr_taken ##0 !mapped(s_axi_awaddr) |=> s_axi_bresp == eic_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_unmapped: assert property (s_rd_bad |=> s_axi_rresp == eic_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_ctrl_bits: assert property (s_axi_rvalid && rdc_r |-> (s_axi_rdata & ~32'hce) == 32'h0)
        else $error("control register shows bits it does not hold");
    a_port_copy: assert property (!func_r && !$past(func_r) && !$past(sys_rst_i) |->
        shared_port_pin_o == $past(irq_pin_i[0]))
        else $error("port output does not follow shared pin");
    a_irq_master: assert property (!mstr_r && !$past(mstr_r) |-> !irq_o)
        else $error("interrupt raised without master enable");
endmodule

bind eic_top eic_monitor #(.AW(AW)) u_mon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .irq_pin_i(irq_pin_i),
    .shared_port_pin_o(shared_port_pin_o), .irq_o(irq_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

`default_nettype wire

// *** tb/test_ext_irq_input_conditioner.sv ***
/*
 * Self-checking bench of the conditioner: bus master tasks, pin pulses, one task per scenario.
 * Assumes eic_top, eic_pin_src and the bound checker; low-clock divider set to 8.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ext_irq_input_conditioner;
    localparam logic [11:0] A_CTRL = {2'h0, eic_pkg::CTRL_IDX, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, eic_pkg::STAT_IDX, 2'h0};
    localparam logic [11:0] A_MASK = {2'h0, eic_pkg::MASK_IDX, 2'h0};
    localparam logic [11:0] A_MSTR = {2'h0, eic_pkg::MSTR_IDX, 2'h0};

    logic clock_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic slow_mode_i = 1'h0;
    logic go = 1'h0;
    logic [2:0] idx = 3'h0;
    logic [7:0] len = 8'h0;
    logic [4:0] pins;
    logic port_o, irq_o, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    int miscompares = 0;
    int checks = 0;

    always #5 clock_i = ~clock_i;

    eic_pin_src src (.clock_i(clock_i), .go_i(go), .idx_i(idx), .len_i(len), .pin_o(pins));

    eic_top #(.LOW_DIV(8)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .irq_pin_i(pins),
        .slow_mode_i(slow_mode_i), .shared_port_pin_o(port_o), .irq_o(irq_o),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s = 4'h1);
        logic aw_ok;
        logic w_ok;
        @(posedge clock_i);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clock_i);
            if (awready)
            begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready)
            begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clock_i); while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clock_i); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clock_i); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    // Pulls pin i low for n cycles, then waits w cycles from the start
    task automatic pulse(input int i, input int n, input int w);
        @(posedge clock_i);
        go <= 1'h1;
        idx <= i[2:0];
        len <= n[7:0];
        @(posedge clock_i);
        go <= 1'h0;
        repeat (w) @(posedge clock_i);
    endtask

    task automatic st(input logic [4:0] e);
        rd(A_STAT);
        chk({27'h0, d[4:0]}, {27'h0, e});
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge clock_i);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask

    task automatic t_reset;
        rd(A_CTRL);
        chk(d, 32'h0);
        wr(A_CTRL, 32'hce, 4'h0);
        rd(A_CTRL);
        chk(d, 32'h0);
        rd(12'h0);
        chk({30'h0, r}, {30'h0, eic_pkg::RESP_SLVERR});
        wr(12'h4, 32'h1);
        chk({30'h0, r}, {30'h0, eic_pkg::RESP_SLVERR});
        pulse(0, 20, 10);
        chk({31'h0, port_o}, 32'h0);
        repeat (40) @(posedge clock_i);
        st(5'h0);
    endtask

    task automatic t_filter;
        int sh[5] = '{1, 14, 6, 6, 1};
        int lg[5] = '{7, 49, 25, 25, 7};
        wr(A_MSTR, 32'h0);
        wr(A_CTRL, 32'hce);
        for (int i = 0; i < 5; i++)
        begin
            pulse(i, sh[i], sh[i] + 60);
            st(5'h0);
            pulse(i, lg[i], lg[i] + 60);
            st(5'(1 << i));
            wr(A_STAT, 32'h1f);
        end
        wr(A_CTRL, 32'h4e);
        pulse(1, 62, 262);
        st(5'h0);
        pulse(1, 193, 393);
        st(5'h02);
        wr(A_STAT, 32'h1f);
    endtask

    task automatic t_edges;
        for (int es = 0; es < 2; es++)
        begin
            wr(A_CTRL, es == 1 ? 32'hce : 32'hc0);
            for (int i = 0; i < 5; i++)
            begin
                pulse(i, 60, 45);
                st((es == 1 || i == 0 || i == 4) ? 5'(1 << i) : 5'h0);
                repeat (80) @(posedge clock_i);
                st(5'(1 << i));
                wr(A_STAT, 32'h1f);
            end
        end
    endtask

    task automatic t_irq;
        wr(A_MASK, 32'h1f);
        pulse(2, 30, 80);
        irq_is(1'h0);
        wr(A_MSTR, 32'h1);
        irq_is(1'h1);
        wr(A_MASK, 32'h0);
        irq_is(1'h0);
        wr(A_MASK, 32'h1f);
        wr(A_STAT, 32'h1f);
        wr(A_MSTR, 32'h3);
        pulse(3, 30, 80);
        irq_is(1'h0);
        wr(A_MSTR, 32'h1);
        irq_is(1'h1);
        wr(A_STAT, 32'h1f);
        irq_is(1'h0);
        wr(A_MSTR, 32'h5);
        pulse(4, 30, 80);
        irq_is(1'h0);
        wr(A_MSTR, 32'h1);
        irq_is(1'h1);
        wr(A_STAT, 32'h1f);
        irq_is(1'h0);
        wr(A_MSTR, 32'h0);
    endtask

    task automatic t_slow;
        slow_mode_i <= 1'h1;
        pulse(0, 4, 60);
        st(5'h0);
        pulse(0, 28, 100);
        st(5'h01);
        wr(A_STAT, 32'h1f);
        slow_mode_i <= 1'h0;
    endtask

    initial
    begin
        #200_000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        t_reset();
        t_filter();
        t_edges();
        t_irq();
        t_slow();
        end_of_test();
    end
endmodule

`default_nettype wire
